// ### keypad_matrix_scanner.sv
// Keypad matrix scanner: Wishbone classic register slave and 4x4 scan engine.
// Assumes external pulls on every line; idle scan lines are left undriven.
module keypad_matrix_scanner #(
   parameter int LINES = keypad_pkg::LINES
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [3:0]  input_line_i,
   output logic      [3:0]  drive_line_o,
   output logic      [3:0]  drive_line_oe_o,
   output logic             irq_o
);

   keypad_pkg::state_type s_r;
   keypad_pkg::state_type s_nxt;
   logic                  take;
   logic                  wr;
   logic                  rd;
   logic                  sample;
   logic [15:0]           row_mask;
   logic [3:0]            raw;
   logic [3:0]            row_bits;
   logic [15:0]           set_vec;
   logic [31:0]           wmask;
   logic [31:0]           cw;

   generate
      if (LINES != 4) begin : g_check
         $error("keypad_matrix_scanner serves exactly four scan and four sense lines");
      end
   endgenerate

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] val,
                                         input logic [31:0] m);
      return (old & ~m) | (val & m);
   endfunction : merge

   function automatic logic [31:0] ctrl_word(input keypad_pkg::ctrl_type c);
      logic [31:0] w;
      w = 32'h0;
      w[keypad_pkg::CTRL_EN_BIT]     = c.en;
      w[keypad_pkg::CTRL_POL_BIT]    = c.pol;
      w[keypad_pkg::CTRL_SINGLE_BIT] = c.single;
      w[keypad_pkg::CTRL_AUTO_BIT]   = c.auto_clr;
      return w;
   endfunction : ctrl_word

   // Next enabled scan line after cur, wrapping; cur itself if it is the only one
   function automatic logic [1:0] next_row(input logic [1:0] cur,
                                           input logic [3:0] en);
      logic [1:0] r;
      logic [1:0] pick;
      pick = cur;
      for (int i = 4; i >= 1; i--) begin
         r = cur + 2'(i);
         if (en[r]) begin
            pick = r;
         end
      end
      return pick;
   endfunction : next_row

   function automatic logic [3:0] lowest_one(input logic [3:0] v);
      return v & (~v + 4'h1);
   endfunction : lowest_one

   always_comb begin
      s_nxt    = s_r;
      take     = wb_cyc_i && wb_stb_i && !s_r.ack;
      wr       = take && wb_we_i;
      rd       = take && !wb_we_i;
      wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      cw       = merge(ctrl_word(s_r.ctrl), wb_dat_i, wmask);
      sample   = 1'b0;
      set_vec  = 16'h0;
      row_mask = 16'h000f << {s_r.row, 2'b00};

      s_nxt.ack   = take;
      s_nxt.sync1 = input_line_i;
      s_nxt.sync2 = s_r.sync1;

      // Scan sequencing; interval is scan_time + 1 clocks
      case (s_r.fsm)
         keypad_pkg::ST_IDLE: begin
            if (s_r.ctrl.en && (|s_r.drive_on)) begin
               s_nxt.fsm = keypad_pkg::ST_SCAN;
               s_nxt.row = next_row(2'd3, s_r.drive_on);
               s_nxt.div = s_r.scan_time;
            end
         end
         keypad_pkg::ST_SCAN: begin
            if (!s_r.ctrl.en || !(|s_r.drive_on)) begin
               s_nxt.fsm = keypad_pkg::ST_IDLE;
            end else if (s_r.div == 13'h0) begin
               sample    = s_r.drive_on[s_r.row];
               s_nxt.div = s_r.scan_time;
               s_nxt.row = next_row(s_r.row, s_r.drive_on);
            end else begin
               s_nxt.div = s_r.div - 13'h1;
            end
         end
         default: begin
            s_nxt.fsm = keypad_pkg::ST_IDLE;
         end
      endcase

      // Sampling at the end of the interval gives the lines time to settle
      raw = (s_r.ctrl.pol ? s_r.sync2 : ~s_r.sync2) & s_r.sense_on;
      if (s_r.ctrl.single) begin
         // Earlier key holds until its own line is rescanned and found released
         row_bits = ((s_r.value & ~row_mask) != 16'h0) ? 4'h0 : lowest_one(raw);
      end else begin
         row_bits = raw;
      end

      // Live key vector
      if (rd && wb_adr_i == keypad_pkg::ADR_VAL && s_r.ctrl.auto_clr) begin
         s_nxt.value = 16'h0;
      end
      if (wr && wb_adr_i == keypad_pkg::ADR_CTRL && wb_sel_i[0]
          && wb_dat_i[keypad_pkg::CTRL_VCLR_BIT]) begin
         s_nxt.value = 16'h0;
      end
      if (sample) begin
         set_vec     = 16'({12'h0, row_bits} << {s_r.row, 2'b00});
         s_nxt.value = (s_nxt.value & ~row_mask) | set_vec;
      end

      // Pending bits: a key seen in the clearing cycle stays set
      if (wr && wb_adr_i == keypad_pkg::ADR_CLR) begin
         s_nxt.pending = s_r.pending & ~(wb_dat_i[15:0] & wmask[15:0]);
      end
      s_nxt.pending = s_nxt.pending | set_vec;

      // Register writes
      if (wr) begin
         case (wb_adr_i)
            keypad_pkg::ADR_MASK: begin
               s_nxt.mask = 16'(merge({16'h0, s_r.mask}, wb_dat_i, wmask));
            end
            keypad_pkg::ADR_CTRL: begin
               s_nxt.ctrl.en       = cw[keypad_pkg::CTRL_EN_BIT];
               s_nxt.ctrl.pol      = cw[keypad_pkg::CTRL_POL_BIT];
               s_nxt.ctrl.single   = cw[keypad_pkg::CTRL_SINGLE_BIT];
               s_nxt.ctrl.auto_clr = cw[keypad_pkg::CTRL_AUTO_BIT];
            end
            keypad_pkg::ADR_LINE: begin
               s_nxt.sense_on = 4'(merge({24'h0, s_r.sense_on, s_r.drive_on},
                                         wb_dat_i, wmask) >> keypad_pkg::LINE_SENSE_LSB);
               s_nxt.drive_on = 4'(merge({24'h0, s_r.sense_on, s_r.drive_on},
                                         wb_dat_i, wmask) >> keypad_pkg::LINE_DRIVE_LSB);
            end
            keypad_pkg::ADR_TIME: begin
               s_nxt.scan_time = 13'(merge({19'h0, s_r.scan_time}, wb_dat_i, wmask));
            end
            default: begin
            end
         endcase
      end

      // Read data, latched with the acknowledge; unmapped reads give zero
      s_nxt.dat = 32'h0;
      if (rd) begin
         case (wb_adr_i)
            keypad_pkg::ADR_MASK: s_nxt.dat = {16'h0, s_r.mask};
            keypad_pkg::ADR_SRC:  s_nxt.dat = {16'h0, s_r.pending & ~s_r.mask};
            keypad_pkg::ADR_CLR:  s_nxt.dat = {16'h0, s_r.pending};
            keypad_pkg::ADR_CTRL: s_nxt.dat = ctrl_word(s_r.ctrl);
            keypad_pkg::ADR_LINE: s_nxt.dat = {24'h0, s_r.sense_on, s_r.drive_on};
            keypad_pkg::ADR_TIME: s_nxt.dat = {19'h0, s_r.scan_time};
            keypad_pkg::ADR_VAL:  s_nxt.dat = {16'h0, s_r.value};
            default:              s_nxt.dat = 32'h0;
         endcase
      end

      // Open-drain style: only the active line is driven, the rest float on pulls
      s_nxt.drive_lvl = s_nxt.ctrl.pol;
      if (s_nxt.fsm == keypad_pkg::ST_SCAN) begin
         s_nxt.drive_oe = (4'h1 << s_nxt.row) & s_nxt.drive_on;
      end else begin
         s_nxt.drive_oe = 4'h0;
      end

      s_nxt.irq = |(s_nxt.pending & ~s_nxt.mask);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= keypad_pkg::STATE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign wb_dat_o        = s_r.dat;
   assign wb_ack_o        = s_r.ack;
   assign drive_line_o    = {4{s_r.drive_lvl}};
   assign drive_line_oe_o = s_r.drive_oe;
   assign irq_o           = s_r.irq;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_clr_write;
      wr && wb_adr_i == keypad_pkg::ADR_CLR;
   endsequence

   sequence s_clr_read;
      rd && wb_adr_i == keypad_pkg::ADR_CLR;
   endsequence

   sequence s_multi_sample;
      sample && !s_r.ctrl.single;
   endsequence

   a_mask_reset: assert property ($past(rst_i) |-> s_r.mask == keypad_pkg::MASK_RST)
      else $error("mask not all ones after reset");

   a_irq_level: assert property (irq_o == (|(s_r.pending & ~s_r.mask)))
      else $error("interrupt output disagrees with unmasked pending bits");

   a_clear_write: assert property (
      (s_clr_write ##0 set_vec == 16'h0) |=>
         ((s_r.pending & $past(wb_dat_i[15:0] & wmask[15:0])) == 16'h0)
         && ((s_r.pending ^ $past(s_r.pending)) & ~$past(wb_dat_i[15:0])) == 16'h0)
      else $error("clear write did not act per bit");

   a_clear_read: assert property (
      s_clr_read |=> wb_ack_o && wb_dat_o == {16'h0, $past(s_r.pending)})
      else $error("clear register read is not the unmasked pending vector");

   a_source_read: assert property (
      (rd && wb_adr_i == keypad_pkg::ADR_SRC) |=>
         wb_dat_o[15:0] == ($past(s_r.pending) & ~$past(s_r.mask)))
      else $error("source register read is not the masked pending vector");

   a_idle_off: assert property (!s_r.ctrl.en |=> drive_line_oe_o == 4'h0 && !sample)
      else $error("scan active while disabled");

   a_drive_level: assert property (drive_line_o == {4{s_r.ctrl.pol}})
      else $error("drive level does not follow polarity");

   a_drive_onehot: assert property (
      $onehot0(drive_line_oe_o) && (drive_line_oe_o & ~s_r.drive_on) == 4'h0)
      else $error("more than one or a disabled scan line driven");

   a_single_key: assert property (
      sample && s_r.ctrl.single && $onehot0(s_r.value) |=> $onehot0(s_r.value))
      else $error("single mode registered more than one key");

   a_auto_clear: assert property (
      (rd && wb_adr_i == keypad_pkg::ADR_VAL && s_r.ctrl.auto_clr && !sample)
         |=> s_r.value == 16'h0)
      else $error("auto clear did not clear key values");

   a_manual_clear: assert property (
      (wr && wb_adr_i == keypad_pkg::ADR_CTRL && wb_sel_i[0] && wb_dat_i[0] && !sample)
         |=> s_r.value == 16'h0 ##1 (!wb_ack_o || wb_dat_o[0] == 1'b0))
      else $error("manual clear failed or bit did not self clear");

   a_scan_period: assert property (
      sample |-> s_r.div == 13'h0 ##1 s_r.div == $past(s_r.scan_time))
      else $error("scan interval reload wrong");

   property p_bit_map;
      logic [1:0] r;
      logic [3:0] b;
      (s_multi_sample, r = s_r.row, b = raw) |=> s_r.value[{r, 2'b00} +: 4] == b;
   endproperty

   a_bit_map: assert property (p_bit_map)
      else $error("key bit not at four times scan line plus sense line");

endmodule : keypad_matrix_scanner

// ### keypad_pkg.sv
// Constants, register map and state layout of the keypad matrix scanner.
// Assumes a 32-bit classic Wishbone slave with byte addresses on one clock.
// Summary of operation
// - Sixteen mask bits, one per key; set masks, reset masks every key.
// - Pressed keys latch into pending bits; source register shows them masked.
// - Latched pending bits are the held copy of the live key vector.
// - Writing one to a clear register bit drops that pending bit; zero keeps it.
// - Reading the clear register returns pending bits before masking.
// - Scanning runs only while the enable bit is one; reset leaves it zero.
// - Polarity bit sets drive and sense level; board fits matching pull resistors.
// - Mode bit one: only a single pressed key is registered at a time.
// - Mode bit zero: any number of simultaneous keys are registered.
// - With auto-clear set, reading the key value register clears it.
// - Writing one to the value clear bit clears key values; bit reads zero.
// - Line enable bits 7..4 gate sense lines, 3..0 gate scan lines; reset off.
// - Scan interval is scan time plus one clocks; field resets to maximum.
// - Key value register is a live view; each scan interval refreshes the four bits of one scan line.
// - Key bit index is four times scan line plus sense line.
package keypad_pkg;

   localparam int LINES  = 4;
   localparam int KEYS   = 16;
   localparam int TIME_W = 13;

   localparam logic [7:0] ADR_MASK = 8'h00;
   localparam logic [7:0] ADR_SRC  = 8'h04;
   localparam logic [7:0] ADR_CLR  = 8'h08;
   localparam logic [7:0] ADR_CTRL = 8'h0c;
   localparam logic [7:0] ADR_LINE = 8'h10;
   localparam logic [7:0] ADR_TIME = 8'h14;
   localparam logic [7:0] ADR_VAL  = 8'h18;

   localparam int CTRL_EN_BIT     = 5;
   localparam int CTRL_POL_BIT    = 4;
   localparam int CTRL_SINGLE_BIT = 3;
   localparam int CTRL_AUTO_BIT   = 1;
   localparam int CTRL_VCLR_BIT   = 0;
   localparam int LINE_SENSE_LSB  = 4;
   localparam int LINE_DRIVE_LSB  = 0;

   localparam logic [15:0] MASK_RST = 16'hffff;
   localparam logic [12:0] TIME_RST = 13'h1fff;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SCAN = 2'b10
   } scan_state_type;

   typedef struct packed {
      logic en;
      logic pol;
      logic single;
      logic auto_clr;
   } ctrl_type;

   typedef struct packed {
      scan_state_type fsm;
      logic [15:0]    mask;
      logic [15:0]    pending;
      logic [15:0]    value;
      ctrl_type       ctrl;
      logic [3:0]     sense_on;
      logic [3:0]     drive_on;
      logic [12:0]    scan_time;
      logic [12:0]    div;
      logic [1:0]     row;
      logic [3:0]     sync1;
      logic [3:0]     sync2;
      logic [3:0]     drive_oe;
      logic           drive_lvl;
      logic           irq;
      logic           ack;
      logic [31:0]    dat;
   } state_type;

   localparam state_type STATE_RST = '{
      fsm:       ST_IDLE,
      mask:      MASK_RST,
      scan_time: TIME_RST,
      default:   '0
   };

endpackage : keypad_pkg

// ### key_matrix_model.sv
// Passive 4x4 key matrix with pull resistors on the sense lines.
// Assumes the bench supplies the pressed-key pattern and the pull direction.
module key_matrix_model (
   input  wire logic        pull_up_i,
   input  wire logic [15:0] pressed_i,
   input  wire logic [3:0]  drive_line_i,
   input  wire logic [3:0]  drive_oe_i,
   output logic      [3:0]  input_line_o
);
   timeunit 1ns;
   timeprecision 1ps;

   always_comb begin
      for (int s = 0; s < 4; s++) begin
         // Open sense line rests on the board pull
         input_line_o[s] = pull_up_i;
         for (int r = 0; r < 4; r++) begin
            if (drive_oe_i[r] && pressed_i[4*r+s]) begin
               input_line_o[s] = drive_line_i[r];
            end
         end
      end
   end
endmodule : key_matrix_model

// ### keypad_matrix_scanner_bench.sv
// Self-checking bench for the keypad scanner: Wishbone tasks, key matrix model.
// Assumes a short scan time of 4 so a full rotation takes 20 clocks.
module keypad_matrix_scanner_bench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic chk; logic [31:0] exp;} note_type;
   logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, irq, pol = 0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0, sense, drv, oe, prev_oe = 4'h0;
   logic [31:0] wdat = 32'h0, rdat;
   logic [15:0] keys = 16'h0000, pat;
   logic [31:0] rst_val [8] = '{32'hffff, 0, 0, 0, 0, 32'h1fff, 0, 0};
   int          fails = 0, num_checks = 0, run = 0;
   note_type    notes[$];
   note_type    cur;

   keypad_matrix_scanner keypad_matrix_scanner_i (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .input_line_i(sense), .drive_line_o(drv),
      .drive_line_oe_o(oe), .irq_o(irq));
   key_matrix_model key_matrix_model_i (.pull_up_i(!pol), .pressed_i(keys),
      .drive_line_i(drv), .drive_oe_i(oe), .input_line_o(sense));

   always #2 clk = ~clk;

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   // Single classic cycle; held until ack is sampled high
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] exp);
      int n;
      notes.push_back('{!w, exp});
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      // A missing acknowledge ends the run; the queued note would misalign
      if (n >= 50) begin
         fails++;
         $display("BAD %0t no acknowledge", $time);
         final_report();
      end else begin
         cyc <= 1'b0;
         stb <= 1'b0;
      end
   endtask : acc

   function automatic logic [31:0] ctl(input logic en, input logic one, input logic au,
                                       input logic clr);
      return {26'h0, en, pol, one, 1'b0, au, clr};
   endfunction : ctl

   task automatic final_report();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report

   always @(posedge clk) begin
      if (ack === 1'b1) begin
         if (notes.size() == 0) begin
            fails++;
            $display("BAD %0t unexpected acknowledge", $time);
         end else begin
            cur = notes.pop_front();
            if (cur.chk) check(rdat, cur.exp, "read data");
         end
      end
   end

   // Scan line watcher: level, one-hot, interval length and rotation order
   always @(posedge clk) begin
      if (!rst) begin
         if (oe != 4'h0) check({28'h0, drv}, {28'h0, {4{pol}}}, "drive level");
         check({28'h0, oe & (oe - 4'h1)}, 32'h0, "one line driven");
         if (oe !== prev_oe) begin
            if (oe != 4'h0 && prev_oe != 4'h0) begin
               check(32'(run), 32'd5, "interval");
               check({28'h0, oe}, {28'h0, prev_oe[2:0], prev_oe[3]}, "rotation");
            end
            run = 1;
         end else begin
            run++;
         end
         prev_oe = oe;
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      $display("BAD %0t watchdog expired", $time);
      final_report();
   end

   initial begin
      void'($urandom(12));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) acc(1'b0, 8'(4 * i), 0, rst_val[i]);
      pat = 16'($urandom) | 16'h0001;
      pol <= 1'($urandom);
      acc(1'b1, 8'h14, 32'h4, 0);
      acc(1'b1, 8'h10, 32'hff, 0);
      acc(1'b1, 8'h0c, ctl(1, 0, 0, 0), 0);
      keys <= pat;
      repeat (60) @(posedge clk);
      acc(1'b0, 8'h18, 0, {16'h0, pat});
      acc(1'b0, 8'h08, 0, {16'h0, pat});
      acc(1'b0, 8'h04, 0, 0);
      check({31'h0, irq}, 0, "irq masked");
      acc(1'b1, 8'h00, 0, 0);
      repeat (3) @(posedge clk);
      check({31'h0, irq}, 1, "irq raised");
      acc(1'b0, 8'h04, 0, {16'h0, pat});
      keys <= 16'h0000;
      repeat (60) @(posedge clk);
      acc(1'b0, 8'h18, 0, 0);
      acc(1'b0, 8'h08, 0, {16'h0, pat});
      acc(1'b1, 8'h08, 32'h00ff, 0);
      acc(1'b0, 8'h08, 0, {16'h0, pat & 16'hff00});
      acc(1'b1, 8'h08, 32'hffff, 0);
      repeat (3) @(posedge clk);
      check({31'h0, irq}, 0, "irq cleared");
      acc(1'b1, 8'h10, 32'h1f, 0);
      keys <= 16'hffff;
      repeat (60) @(posedge clk);
      acc(1'b0, 8'h18, 0, 32'h1111);
      acc(1'b1, 8'h0c, ctl(0, 0, 0, 0), 0);
      repeat (10) @(posedge clk);
      check({28'h0, oe}, 0, "scanner idle");
      acc(1'b0, 8'h18, 0, 32'h1111);
      acc(1'b1, 8'h0c, ctl(0, 0, 0, 1), 0);
      acc(1'b0, 8'h18, 0, 0);
      acc(1'b0, 8'h0c, 0, ctl(0, 0, 0, 0));
      acc(1'b1, 8'h10, 32'hff, 0);
      keys <= 16'h8421;
      acc(1'b1, 8'h0c, ctl(1, 0, 1, 0), 0);
      repeat (60) @(posedge clk);
      acc(1'b1, 8'h0c, ctl(0, 0, 1, 0), 0);
      acc(1'b0, 8'h18, 0, 32'h8421);
      acc(1'b0, 8'h18, 0, 0);
      // Other polarity for the last pass; scanner is idle while the pulls swap
      pol <= ~pol;
      acc(1'b1, 8'h0c, ctl(0, 0, 0, 1), 0);
      keys <= 16'h0006;
      acc(1'b1, 8'h0c, ctl(1, 1, 0, 0), 0);
      repeat (60) @(posedge clk);
      acc(1'b1, 8'h0c, ctl(0, 0, 0, 0), 0);
      acc(1'b0, 8'h18, 0, 32'h0002);
      repeat (3) @(posedge clk);
      final_report();
   end
endmodule : keypad_matrix_scanner_bench
